// ---- core/ccd_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1 - watchdog clear zeroes the counter and sets both active-low status flags; in the code an expiry or sleep entry in the same cycle wins
// RULE2 - watchdog clear also zeroes the watchdog prescaler
// RULE3 - call via accumulator pushes program counter plus one onto the stack first
// RULE4 - new pc takes accumulator in low byte and upper latch in high bits
// RULE5 - call via accumulator takes two cycles and leaves all flags alone
// RULE6 - invert file register; destination bit picks accumulator or file; zero updated
// RULE7 - file operands are seven-bit addresses, 0 to 127, in the current bank
// RULE8 - clearing a file register writes zero and sets the zero flag
// RULE9 - clearing the accumulator writes zero and sets the zero flag
// RULE10 - decrement file register, store by destination bit, update zero flag
// RULE11 - decrement and skip: zero result discards next fetch, two cycles, no flags
// RULE12 - zero flag set when the eight-bit result is zero, else cleared
module ccd_exec
#(
   parameter int PRESCALE_W = ccd_pkg::WDT_PRESCALE_W,
   parameter int COUNT_W = ccd_pkg::WDT_COUNT_W
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic op_valid,
   input wire ccd_pkg::ccd_op_t op_code,
   input wire logic [6:0] file_addr,
   input wire logic dest_sel,
   input wire logic [7:0] file_rdata,
   input wire logic [14:0] pc_current,
   input wire logic [6:0] pc_upper_latch,
   input wire logic sleep_enter,
   output logic op_ready,
   output logic file_we,
   output logic [6:0] file_waddr,
   output logic [7:0] file_wdata,
   output logic [7:0] acc_value,
   output logic zero_flag,
   output logic expiry_flag_n,
   output logic sleep_entry_flag_n,
   output logic stack_push,
   output logic [14:0] stack_top,
   output logic pc_load,
   output logic [14:0] pc_load_value,
   output logic fetch_discard,
   output logic [PRESCALE_W-1:0] watchdog_prescaler,
   output logic [COUNT_W-1:0] watchdog_counter
);

   // *********************************************
   // elaboration checks
   // *********************************************
   if (PRESCALE_W < 1 || COUNT_W < 1)
   begin : g_bad_width
      $error("watchdog chain widths must be at least one bit");
   end

   // *********************************************
   // state and data path
   // *********************************************
   ccd_pkg::ccd_state_t state_q;
   ccd_pkg::ccd_state_t state_d;
   logic [7:0] acc_q;
   logic [7:0] file_wdata_q;
   logic [6:0] file_waddr_q;
   logic [14:0] stack_top_q;
   logic [14:0] pc_load_value_q;
   logic [PRESCALE_W-1:0] prescale_q;
   logic [COUNT_W-1:0] count_q;
   // one-bit flags and pulses
   logic zero_q, expiry_n_q, sleep_n_q, file_we_q, stack_push_q, pc_load_q, discard_q;
   logic take, is_op_wdt, is_op_call, is_op_skip, skip_now;
   logic to_acc, to_file, wdt_expire, prescale_wrap;

   ccd_alu_if alu_bus ();

   ccd_alu u_alu
   (
      .bus(alu_bus)
   );

   // feed the data path from the current request
   assign alu_bus.op = op_code;
   assign alu_bus.file_data = file_rdata;
   assign alu_bus.acc_data = acc_q;

   // requests are only taken in the first cycle of an instruction
   assign op_ready = (state_q == ccd_pkg::ST_EXEC);
   assign take = op_valid && op_ready;
   assign is_op_wdt = take && (op_code == ccd_pkg::watchdog_clear_op);
   assign is_op_call = take && (op_code == ccd_pkg::call_via_accumulator_op);
   assign is_op_skip = take && (op_code == ccd_pkg::decrement_skip_op);
   assign skip_now = is_op_skip && alu_bus.result_zero; // RULE11

   // route the result by destination bit; clears have fixed targets
   always_comb
   begin
      to_acc = 1'b0;
      to_file = 1'b0;
      if (take)
      begin
         case (op_code)
            ccd_pkg::invert_file_op,
            ccd_pkg::decrement_file_op,
            ccd_pkg::decrement_skip_op:
            begin
               to_acc = (dest_sel == ccd_pkg::DEST_ACC); // RULE6 RULE10 RULE11
               to_file = (dest_sel == ccd_pkg::DEST_FILE);
            end
            ccd_pkg::zero_file_op: to_file = 1'b1; // RULE8
            ccd_pkg::zero_accumulator_op: to_acc = 1'b1; // RULE9
            default: to_acc = 1'b0;
         endcase
      end
   end

   // *********************************************
   // sequencer
   // *********************************************

   // call and a taken skip hold the second cycle; the fetch path must stall on op_ready
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ccd_pkg::ST_EXEC:
            if (is_op_call || skip_now)
               state_d = ccd_pkg::ST_SECOND; // RULE5 RULE11
         ccd_pkg::ST_SECOND: state_d = ccd_pkg::ST_EXEC;
         default: state_d = ccd_pkg::ST_EXEC;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         state_q <= ccd_pkg::ST_EXEC;
      else
         state_q <= state_d;
   end

   // *********************************************
   // accumulator and file write port
   // *********************************************
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         acc_q <= ccd_pkg::ACC_RESET;
      else if (to_acc)
         acc_q <= alu_bus.result;
   end

   // address is already 7 bits wide, so it cannot leave the bank
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         file_we_q <= 1'b0;
         file_waddr_q <= 7'h00;
         file_wdata_q <= ccd_pkg::ZERO_BYTE;
      end
      else
      begin
         file_we_q <= to_file;
         if (to_file)
         begin
            file_waddr_q <= file_addr; // RULE7
            file_wdata_q <= alu_bus.result;
         end
      end
   end

   // *********************************************
   // zero flag
   // *********************************************

   // skip and call leave the flag alone
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         zero_q <= ccd_pkg::ZERO_FLAG_RESET;
      else if (take)
      begin
         case (op_code)
            ccd_pkg::zero_file_op,
            ccd_pkg::zero_accumulator_op: zero_q <= 1'b1; // RULE8 RULE9
            ccd_pkg::invert_file_op,
            ccd_pkg::decrement_file_op: zero_q <= alu_bus.result_zero; // RULE12
            default: zero_q <= zero_q; // RULE5 RULE11
         endcase
      end
   end

   // *********************************************
   // call: stack push and program counter load
   // *********************************************
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stack_push_q <= 1'b0;
         stack_top_q <= 15'h0000;
         pc_load_q <= 1'b0;
         pc_load_value_q <= 15'h0000;
      end
      else
      begin
         stack_push_q <= is_op_call;
         pc_load_q <= is_op_call;
         if (is_op_call)
         begin
            stack_top_q <= pc_current + ccd_pkg::PC_STEP; // RULE3
            pc_load_value_q <= {pc_upper_latch, acc_q}; // RULE4
         end
      end
   end

   // discard pulse for the already fetched next instruction
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         discard_q <= 1'b0;
      else
         discard_q <= skip_now; // RULE11
   end

   // *********************************************
   // watchdog chain and status flags
   // *********************************************
   assign prescale_wrap = (prescale_q == {PRESCALE_W{1'b1}});
   assign wdt_expire = prescale_wrap && (count_q == {COUNT_W{1'b1}});

   // clear restarts the whole chain from zero
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prescale_q <= '0;
         count_q <= '0;
      end
      else if (is_op_wdt)
      begin
         prescale_q <= '0; // RULE2
         count_q <= '0; // RULE1
      end
      else
      begin
         prescale_q <= prescale_q + 1'b1;
         if (prescale_wrap)
         begin
            count_q <= count_q + 1'b1;
         end
      end
   end

   // a trip in the same cycle as the clear wins, so no expiry is lost
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         expiry_n_q <= ccd_pkg::FLAG_N_RESET;
         sleep_n_q <= ccd_pkg::FLAG_N_RESET;
      end
      else
      begin
         if (wdt_expire)
            expiry_n_q <= ccd_pkg::FLAG_N_TRIP;
         else if (is_op_wdt)
            expiry_n_q <= ccd_pkg::FLAG_N_SET; // RULE1
         if (sleep_enter)
            sleep_n_q <= ccd_pkg::FLAG_N_TRIP;
         else if (is_op_wdt)
            sleep_n_q <= ccd_pkg::FLAG_N_SET; // RULE1
      end
   end

   // *********************************************
   // outputs
   // *********************************************
   assign file_we = file_we_q;
   assign file_waddr = file_waddr_q;
   assign file_wdata = file_wdata_q;
   assign acc_value = acc_q;
   assign zero_flag = zero_q;
   assign expiry_flag_n = expiry_n_q;
   assign sleep_entry_flag_n = sleep_n_q;
   assign stack_push = stack_push_q;
   assign stack_top = stack_top_q;
   assign pc_load = pc_load_q;
   assign pc_load_value = pc_load_value_q;
   assign fetch_discard = discard_q;
   assign watchdog_prescaler = prescale_q;
   assign watchdog_counter = count_q;

endmodule
`default_nettype wire

// ---- core/ccd_pkg.sv ----
// *********************************************
// shared constants and types
// *********************************************
package ccd_pkg;

   // data path widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PC_W = 15;
   localparam int LATCH_W = 7;
   localparam int PC_LOW_W = 8;

   // highest file-register address inside the current bank
   localparam logic [6:0] ADDR_MAX = 7'h7f;

   // destination select encodings
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // constant values used by the data path
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [14:0] PC_STEP = 15'h0001;

   // reset values and status flag levels
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic ZERO_FLAG_RESET = 1'b0;
   localparam logic FLAG_N_RESET = 1'b1;
   localparam logic FLAG_N_SET = 1'b1;
   localparam logic FLAG_N_TRIP = 1'b0;

   // default watchdog chain widths
   localparam int WDT_PRESCALE_W = 8;
   localparam int WDT_COUNT_W = 8;

   // instruction group served by this block
   typedef enum logic [2:0]
   {
      watchdog_clear_op,
      call_via_accumulator_op,
      invert_file_op,
      zero_file_op,
      zero_accumulator_op,
      decrement_file_op,
      decrement_skip_op
   } ccd_op_t;

   // sequencing of one- and two-cycle instructions
   typedef enum logic
   {
      ST_EXEC,
      ST_SECOND
   } ccd_state_t;

endpackage

// ---- core/ccd_alu_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// *********************************************
// operands and result between sequencer and data path
// *********************************************
interface ccd_alu_if;
   ccd_pkg::ccd_op_t op;
   logic [7:0] file_data;
   logic [7:0] acc_data;
   logic [7:0] result;
   logic result_zero;

   modport seq (output op, output file_data, output acc_data, input result, input result_zero);
   modport alu (input op, input file_data, input acc_data, output result, output result_zero);
endinterface
`default_nettype wire

// ---- core/ccd_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
// *********************************************
// combinational data path
// *********************************************
module ccd_alu
(
   ccd_alu_if.alu bus
);

   // result per operation; clears give a zero byte
   always_comb
   begin
      case (bus.op)
         ccd_pkg::invert_file_op: bus.result = ~bus.file_data; // RULE6
         ccd_pkg::decrement_file_op,
         ccd_pkg::decrement_skip_op: bus.result = bus.file_data - ccd_pkg::ONE_BYTE; // RULE10
         ccd_pkg::zero_file_op,
         ccd_pkg::zero_accumulator_op: bus.result = ccd_pkg::ZERO_BYTE;
         default: bus.result = bus.acc_data;
      endcase
   end

   // zero test on the full eight-bit result
   assign bus.result_zero = (bus.result == ccd_pkg::ZERO_BYTE); // RULE12

endmodule
`default_nettype wire

// ---- testbench/ccd_exec_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker for the execution block
// ****************************************
module ccd_exec_props
#(
   parameter int PRESCALE_W = 8,
   parameter int COUNT_W = 8
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic op_valid,
   input wire ccd_pkg::ccd_op_t op_code,
   input wire logic [6:0] file_addr,
   input wire logic dest_sel,
   input wire logic [7:0] file_rdata,
   input wire logic [14:0] pc_current,
   input wire logic [6:0] pc_upper_latch,
   input wire logic sleep_enter,
   input wire logic op_ready,
   input wire logic file_we,
   input wire logic [6:0] file_waddr,
   input wire logic [7:0] file_wdata,
   input wire logic [7:0] acc_value,
   input wire logic zero_flag,
   input wire logic expiry_flag_n,
   input wire logic sleep_entry_flag_n,
   input wire logic stack_push,
   input wire logic [14:0] stack_top,
   input wire logic pc_load,
   input wire logic [14:0] pc_load_value,
   input wire logic fetch_discard,
   input wire logic [PRESCALE_W-1:0] watchdog_prescaler,
   input wire logic [COUNT_W-1:0] watchdog_counter
);
   // a request counts only when the block is ready for it
   wire logic take = op_valid && op_ready;
   // expiry and sleep entry win over a clear in the same cycle
   wire logic quiet = !sleep_enter && !((&watchdog_prescaler) && (&watchdog_counter));
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // two-cycle ops refuse exactly one cycle
   sequence s_gap;
      !op_ready ##1 op_ready;
   endsequence
   chk_wdt_count_zero: assert property
      (take && op_code == ccd_pkg::watchdog_clear_op |=> watchdog_counter == '0)
      else $error("watchdog counter not cleared");
   chk_wdt_flags_set: assert property
      (take && op_code == ccd_pkg::watchdog_clear_op && quiet
       |=> expiry_flag_n && sleep_entry_flag_n)
      else $error("status flags not set by clear");
   chk_wdt_prescale_zero: assert property
      (take && op_code == ccd_pkg::watchdog_clear_op |=> watchdog_prescaler == '0)
      else $error("prescaler not cleared");
   chk_call_push_top: assert property
      (take && op_code == ccd_pkg::call_via_accumulator_op
       |=> stack_push && stack_top == $past(pc_current) + 15'h0001)
      else $error("return address not pushed");
   chk_call_pc_load: assert property
      (take && op_code == ccd_pkg::call_via_accumulator_op
       |=> pc_load && pc_load_value == {$past(pc_upper_latch), $past(acc_value)})
      else $error("call target wrong");
   chk_call_two_cycle: assert property
      (take && op_code == ccd_pkg::call_via_accumulator_op |=> s_gap and $stable(zero_flag)[*2])
      else $error("call timing or flags wrong");
   chk_invert_acc: assert property
      (take && op_code == ccd_pkg::invert_file_op && !dest_sel
       |=> acc_value == ~$past(file_rdata) && zero_flag == (acc_value == 8'h00) && !file_we)
      else $error("invert to accumulator wrong");
   chk_zero_file: assert property
      (take && op_code == ccd_pkg::zero_file_op
       |=> file_we && file_wdata == 8'h00 && file_waddr == $past(file_addr) && zero_flag)
      else $error("file clear wrong");
   chk_zero_acc: assert property
      (take && op_code == ccd_pkg::zero_accumulator_op |=> acc_value == 8'h00 && zero_flag)
      else $error("accumulator clear wrong");
   chk_dec_file: assert property
      (take && op_code == ccd_pkg::decrement_file_op && dest_sel
       |=> file_we && file_wdata == $past(file_rdata) - 8'h01 && zero_flag == (file_wdata == 8'h00))
      else $error("decrement to file wrong");
   chk_skip_taken: assert property
      (take && op_code == ccd_pkg::decrement_skip_op && file_rdata == 8'h01
       |=> fetch_discard && $stable(zero_flag) ##0 s_gap)
      else $error("skip on zero wrong");
endmodule

bind ccd_exec ccd_exec_props #(.PRESCALE_W(PRESCALE_W), .COUNT_W(COUNT_W)) u_props
(
   .clk_sys, .reset_n, .op_valid, .op_code, .file_addr, .dest_sel, .file_rdata,
   .pc_current, .pc_upper_latch, .sleep_enter, .op_ready, .file_we, .file_waddr,
   .file_wdata, .acc_value, .zero_flag, .expiry_flag_n, .sleep_entry_flag_n,
   .stack_push, .stack_top, .pc_load, .pc_load_value, .fetch_discard,
   .watchdog_prescaler, .watchdog_counter
);
`default_nettype wire

// ---- testbench/ccd_exec_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccd_exec_test;
   // short watchdog chain so expiry happens within a few ops
   localparam int PW = 2;
   localparam int CW = 2;
   logic clk_sys, reset_n, op_valid, dest_sel, sleep_enter;
   ccd_pkg::ccd_op_t op_code;
   logic [6:0] file_addr, pc_upper_latch, file_waddr;
   logic [7:0] file_rdata, file_wdata, acc_value, m_acc, m_wdata, res;
   logic [14:0] pc_current, stack_top, pc_load_value, m_top, m_lval;
   logic op_ready, file_we, zero_flag, expiry_flag_n, sleep_entry_flag_n, stack_push;
   logic pc_load, fetch_discard, m_rdy, m_we, m_z, m_to, m_pd, m_push, m_load, m_disc, trip;
   logic [PW-1:0] watchdog_prescaler;
   logic [CW-1:0] watchdog_counter;
   logic [CW+PW-1:0] wd;
   logic [6:0] m_waddr;
   logic [31:0] seed = 32'h17099f53;
   int num_errors = 0;
   int checked = 0;
   logic [15:0] tbl [12] = '{16'h20ff, 16'h2100, 16'h3000, 16'h4000, 16'h5001, 16'h5100,
      16'h6101, 16'h6001, 16'h6000, 16'h1000, 16'h0000, 16'h1000};

   ccd_exec #(.PRESCALE_W(PW), .COUNT_W(CW)) u_ccd_exec
   (
      .clk_sys, .reset_n, .op_valid, .op_code, .file_addr, .dest_sel, .file_rdata,
      .pc_current, .pc_upper_latch, .sleep_enter, .op_ready, .file_we, .file_waddr,
      .file_wdata, .acc_value, .zero_flag, .expiry_flag_n, .sleep_entry_flag_n,
      .stack_push, .stack_top, .pc_load, .pc_load_value, .fetch_discard,
      .watchdog_prescaler, .watchdog_counter
   );

   // ****************************************
   // reference model and comparison
   // ****************************************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic put(input logic d);
      if (d)
      begin
         m_we = 1'b1;
         m_waddr = file_addr;
         m_wdata = res;
      end
      else
         m_acc = res;
   endtask

   // model updates on the same edge the block samples its inputs
   always @(posedge clk_sys or negedge reset_n)
   begin
      {m_we, m_push, m_load, m_disc} = 4'h0;
      if (!reset_n)
      begin
         {m_acc, m_waddr, m_wdata, m_top, m_lval, wd, m_z} = '0;
         {m_rdy, m_to, m_pd} = 3'h7;
      end
      else
      begin
         // an expiry in the same cycle as a clear wins, as in the block
         trip = &wd;
         wd = wd + 1'b1;
         if (trip)
            m_to = 1'b0;
         if (op_valid && m_rdy)
         begin
            m_rdy = 1'b1;
            case (op_code)
               ccd_pkg::watchdog_clear_op:
               begin
                  wd = '0;
                  if (!trip)
                     m_to = 1'b1;
                  m_pd = 1'b1;
               end
               ccd_pkg::call_via_accumulator_op:
               begin
                  {m_push, m_load, m_rdy} = 3'h6;
                  m_top = pc_current + 15'h0001;
                  m_lval = {pc_upper_latch, m_acc};
               end
               ccd_pkg::zero_file_op:
               begin
                  res = 8'h00;
                  put(1'b1);
                  m_z = 1'b1;
               end
               ccd_pkg::zero_accumulator_op:
               begin
                  m_acc = 8'h00;
                  m_z = 1'b1;
               end
               default:
               begin
                  res = (op_code == ccd_pkg::invert_file_op) ? ~file_rdata : file_rdata - 8'h01;
                  put(dest_sel);
                  if (op_code != ccd_pkg::decrement_skip_op)
                     m_z = (res == 8'h00);
                  else if (res == 8'h00)
                     {m_disc, m_rdy} = 2'h2;
               end
            endcase
         end
         else
            m_rdy = 1'b1;
         if (sleep_enter)
            m_pd = 1'b0;
      end
   end

   // one group of outputs against the model; unknowns count as mismatches
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // every output is compared mid-cycle, after both sides have settled
   always @(negedge clk_sys)
   begin
      if (reset_n)
      begin
         cmp(32'({op_ready, fetch_discard}), 32'({m_rdy, m_disc}));
         cmp(32'({file_we, file_waddr, file_wdata}),
            32'({m_we, m_waddr, m_wdata}));
         cmp(32'({acc_value, zero_flag}),
            32'({m_acc, m_z}));
         cmp(32'({stack_push, stack_top, pc_load, pc_load_value}),
            32'({m_push, m_top, m_load, m_lval}));
         cmp(32'({expiry_flag_n, sleep_entry_flag_n, watchdog_counter, watchdog_prescaler}),
            32'({m_to, m_pd, wd}));
      end
   end

   // ****************************************
   // stimulus
   // ****************************************
   task step(input logic v, input logic [3:0] op, input logic [7:0] fd, input logic d);
      @(posedge clk_sys);
      #1;
      // a refused request stays up until the block can take the next one
      while (!op_ready)
      begin
         @(posedge clk_sys);
         #1;
      end
      op_valid = v;
      op_code = ccd_pkg::ccd_op_t'(op[2:0]);
      file_rdata = fd;
      dest_sel = d;
      file_addr = 7'(rnd());
      pc_current = 15'(rnd());
      pc_upper_latch = 7'(rnd());
      sleep_enter = (rnd() % 16 == 0);
   endtask

   task give_verdict();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // watchdog span covers roughly twice the expected run
   initial
   begin
      #60000;
      num_errors++;
      give_verdict();
   end

   initial
   begin
      {reset_n, op_valid, dest_sel, sleep_enter, file_addr, file_rdata} = '0;
      {pc_current, pc_upper_latch} = '0;
      op_code = ccd_pkg::watchdog_clear_op;
      repeat (5) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      // boundary values back to back; requests stay up through refused cycles
      foreach (tbl[i])
         step(1'b1, tbl[i][15:12], tbl[i][7:0], tbl[i][8]);
      $display("table test done");
      for (int i = 0; i < 400; i++)
         step(1'(rnd()), 4'(rnd() % 7), 8'(rnd()), 1'(rnd()));
      $display("random test done");
      // reset in mid-run; the block must come back to its reset values
      @(posedge clk_sys);
      #1;
      reset_n = 1'b0;
      op_valid = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      $display("reset test done");
      // long idle lets the watchdog expire before a clear
      repeat (40) step(1'b0, 4'h0, 8'h00, 1'b0);
      step(1'b1, 4'h0, 8'h00, 1'b0);
      repeat (3) step(1'b0, 4'h0, 8'h00, 1'b0);
      $display("watchdog test done");
      give_verdict();
   end
endmodule
`default_nettype wire
